// File: seq_engine_consts.svh
`ifndef SEQ_ENGINE_CONSTS_SVH
`define SEQ_ENGINE_CONSTS_SVH

// ****************************************************************
// Clock and time base.
// ****************************************************************
`define CLK_PERIOD_NS     4
`define TICK_NS           10000
`define TICK_CYC          (`TICK_NS / `CLK_PERIOD_NS)
`define REF_HALF_NS       5000
`define REF_HALF_CYC      (`REF_HALF_NS / `CLK_PERIOD_NS)
`define LOAD_LIMIT_NS     20000
`define TIMER_MAX_MS      400
`define TIMER_MAX_TICKS   (`TIMER_MAX_MS * 1000000 / `TICK_NS)

// ****************************************************************
// Register offsets.
// ****************************************************************
`define REG_CTRL          8'h00
`define REG_STATE         8'h04
`define REG_FAULT_LOW     8'h08
`define REG_FAULT_HIGH    8'h0c
`define REG_LIVE_UV       8'h10
`define REG_LIVE_OV       8'h14
`define REG_LIVE_MISC     8'h18
`define REG_SRC           8'h1c
`define REG_HOST_OUT      8'h20
`define REG_IRQ_STAT      8'h24
`define REG_IRQ_MASK      8'h28
`define REG_PROG_ADDR     8'h2c
`define REG_PROG_W0       8'h30
`define REG_PROG_W1       8'h34
`define REG_PROG_W2       8'h38

// ****************************************************************
// Fields of a state definition, word 0.
// ****************************************************************
`define F_OUT_LSB         0
`define F_LATCH_BIT       10
`define F_SEQ_SEL_LSB     11
`define F_SEQ_POL_BIT     15
`define F_SEQ_NEXT_LSB    16
`define F_MON_NEXT_LSB    22
`define F_MON_WARN_BIT    28
`define F_TO_WARN_BIT     29

// ****************************************************************
// Fields of words 1 and 2, and interrupt bits.
// ****************************************************************
`define F_SEQ_DLY_LSB     0
`define F_TO_DLY_LSB      16
`define F_MON_MASK_LSB    0
`define F_MON_EXP_LSB     10
`define F_TO_NEXT_LSB     20
`define IRQ_STATE_CHG     0
`define IRQ_MON_EXIT      1
`define IRQ_TO_EXIT       2
`define IRQ_WARN          3
`define FIRST_STATE       6'h00

`endif

// File: seq_engine_pkg.sv
package seq_engine_pkg;

	typedef enum logic [1:0] {
		ENG_LOAD = 2'b00,
		ENG_RUN  = 2'b01
	} eng_state_t;

	typedef enum logic [1:0] {
		SRC_ENGINE = 2'b00,
		SRC_HOST   = 2'b01,
		SRC_REFCLK = 2'b10,
		SRC_SPARE  = 2'b11
	} out_src_t;

endpackage

// File: input_sync.sv
`timescale 1ns/1ns
`default_nettype none

module input_sync #(
	parameter int WIDTH = 36
) (
	// Clock and reset.
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	// Raw and settled levels.
	input  wire logic [WIDTH-1:0] raw_i,
	output logic      [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;
	wire  [WIDTH-1:0] agree;

	// A bit moves only when the second and third stages agree.
	assign agree      = ~(s2_reg ^ s3_reg);
	assign level_next = (s2_reg & agree) | (level_reg & ~agree);
	assign level_o    = level_reg;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			level_reg <= '0;
		end else begin
			s1_reg    <= raw_i;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			level_reg <= level_next;
		end
	end

endmodule

`default_nettype wire

// File: state_store.sv
`timescale 1ns/1ns
`default_nettype none

module state_store #(
	parameter int DEPTH = 63,
	parameter int WORDS = 3
) (
	// Clock and reset.
	input  wire logic                 clock_i,
	input  wire logic                 rstn_i,
	// Write port.
	input  wire logic                 wr_i,
	input  wire logic [5:0]           wr_idx_i,
	input  wire logic [1:0]           wr_word_i,
	input  wire logic [31:0]          wr_data_i,
	// Read port.
	input  wire logic [5:0]           rd_idx_i,
	output logic      [WORDS*32-1:0]  rd_def_o
);

	logic [WORDS*32-1:0] mem_reg [DEPTH];

	// Indices past the last cell read as an all-zero definition.
	assign rd_def_o = (int'(rd_idx_i) < DEPTH) ? mem_reg[rd_idx_i] : '0;

	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_cell
			for (genvar w = 0; w < WORDS; w++) begin : g_word
				always_ff @(posedge clock_i or negedge rstn_i) begin
					if (!rstn_i) begin
						mem_reg[i][w*32 +: 32] <= '0;
					end else if (wr_i && int'(wr_idx_i) == i && int'(wr_word_i) == w) begin
						mem_reg[i][w*32 +: 32] <= wr_data_i;
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: sequencing_engine.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "seq_engine_consts.svh"
`default_nettype none

module sequencing_engine #(
	parameter int STATES  = 63,
	parameter int INPUTS  = 10,
	parameter int SECONDS = 5
) (
	// Clock and reset.
	input  wire logic              clock_i,
	input  wire logic              rstn_i,
	// Register port.
	input  wire logic [7:0]        addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [31:0]       rdata_o,
	// Supply fault detector and logic inputs.
	input  wire logic [INPUTS-1:0] supply_ok_i,
	input  wire logic [INPUTS-1:0] uv_i,
	input  wire logic [INPUTS-1:0] ov_i,
	input  wire logic              limit_fault_i,
	input  wire logic [SECONDS-1:0] secondary_warn_i,
	// Driver outputs and interrupt.
	output logic      [INPUTS-1:0] driver_output_o,
	output logic                   irq_o
);

	// ****************************************************************
	// Constants and helpers.
	// ****************************************************************
	localparam int SYNC_W = 3 * INPUTS + 1 + SECONDS;
	localparam logic [11:0] TICK_LAST = 12'(`TICK_CYC - 1);
	localparam logic [10:0] REF_LAST  = 11'(`REF_HALF_CYC - 1);
	localparam logic [15:0] TMR_MAX   = 16'(`TIMER_MAX_TICKS);

	function automatic logic pick(input logic [15:0] vec, input logic [3:0] sel);
		pick = vec[sel];
	endfunction

	function automatic logic [15:0] bump(input logic [15:0] cnt);
		bump = (cnt == TMR_MAX) ? cnt : cnt + 16'h0001;
	endfunction

	// ****************************************************************
	// Input synchronisers.
	// ****************************************************************
	wire [SYNC_W-1:0]  sync_lvl;
	wire [INPUTS-1:0]  ok_s;
	wire [INPUTS-1:0]  uv_s;
	wire [INPUTS-1:0]  ov_s;
	wire               lim_s;
	wire [SECONDS-1:0] sec_s;

	input_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clock_i(clock_i),
		.rstn_i (rstn_i),
		.raw_i  ({secondary_warn_i, limit_fault_i, ov_i, uv_i, supply_ok_i}),
		.level_o(sync_lvl)
	);

	assign ok_s  = sync_lvl[INPUTS-1:0];
	assign uv_s  = sync_lvl[2*INPUTS-1:INPUTS];
	assign ov_s  = sync_lvl[3*INPUTS-1:2*INPUTS];
	assign lim_s = sync_lvl[3*INPUTS];
	assign sec_s = sync_lvl[SYNC_W-1:3*INPUTS+1];

	// ****************************************************************
	// State storage and current definition.
	// ****************************************************************
	seq_engine_pkg::eng_state_t eng_reg;
	seq_engine_pkg::eng_state_t eng_next;
	logic [5:0]  cur_reg;
	logic [5:0]  cur_next;
	logic [95:0] def_reg;
	logic [5:0]  prog_idx_reg;
	wire  [95:0] store_def;
	wire         prog_wr;
	wire  [1:0]  prog_word;

	assign prog_wr   = wr_i && (addr_i == `REG_PROG_W0 || addr_i == `REG_PROG_W1 ||
	                            addr_i == `REG_PROG_W2);
	assign prog_word = 2'(addr_i[3:2]);

	state_store #(
		.DEPTH(STATES),
		.WORDS(3)
	) u_store (
		.clock_i  (clock_i),
		.rstn_i   (rstn_i),
		.wr_i     (prog_wr),
		.wr_idx_i (prog_idx_reg),
		.wr_word_i(prog_word),
		.wr_data_i(wdata_i),
		.rd_idx_i (cur_reg),
		.rd_def_o (store_def)
	);

	wire [INPUTS-1:0] d_out      = def_reg[`F_OUT_LSB +: INPUTS];
	wire              d_latch    = def_reg[`F_LATCH_BIT];
	wire [3:0]        d_seq_sel  = def_reg[`F_SEQ_SEL_LSB +: 4];
	wire              d_seq_pol  = def_reg[`F_SEQ_POL_BIT];
	wire [5:0]        d_seq_next = def_reg[`F_SEQ_NEXT_LSB +: 6];
	wire [5:0]        d_mon_next = def_reg[`F_MON_NEXT_LSB +: 6];
	wire              d_mon_warn = def_reg[`F_MON_WARN_BIT];
	wire              d_to_warn  = def_reg[`F_TO_WARN_BIT];
	wire [15:0]       d_seq_dly  = def_reg[32 + `F_SEQ_DLY_LSB +: 16];
	wire [15:0]       d_to_dly   = def_reg[32 + `F_TO_DLY_LSB +: 16];
	wire [INPUTS-1:0] d_mon_mask = def_reg[64 + `F_MON_MASK_LSB +: INPUTS];
	wire [INPUTS-1:0] d_mon_exp  = def_reg[64 + `F_MON_EXP_LSB +: INPUTS];
	wire [5:0]        d_to_next  = def_reg[64 + `F_TO_NEXT_LSB +: 6];

	// ****************************************************************
	// Exit detectors.
	// ****************************************************************
	logic [11:0] seq_pre_reg;
	logic [15:0] seq_cnt_reg;
	logic [11:0] to_pre_reg;
	logic [15:0] to_cnt_reg;
	logic        jump_reg;
	wire         run;
	wire         warn;
	wire         seq_hit;
	wire         seq_exit;
	wire         mon_exit;
	wire         to_exit;
	wire         take;
	wire         jump_wr;

	assign run     = (eng_reg == seq_engine_pkg::ENG_RUN);
	assign jump_wr = wr_i && addr_i == `REG_CTRL && wdata_i[0];

	assign warn = lim_s | (|sec_s);

	assign seq_hit = pick(16'({warn, ok_s}), d_seq_sel) == d_seq_pol;

	assign seq_exit = run && ((seq_hit && seq_cnt_reg >= d_seq_dly) || jump_reg);

	assign mon_exit = run && ((|(d_mon_mask & (ok_s ^ d_mon_exp))) || (d_mon_warn && warn));

	assign to_exit = run && ((d_to_dly != 16'h0000 && to_cnt_reg >= d_to_dly && !seq_hit) ||
	                         (d_to_warn && warn) || jump_reg);
	assign take = mon_exit || to_exit || seq_exit;

	always_comb begin
		cur_next = cur_reg;
		if (mon_exit) begin
			cur_next = d_mon_next;
		end else if (to_exit && !jump_reg) begin
			cur_next = d_to_next;
		end else if (seq_exit) begin
			cur_next = d_seq_next;
		end
	end

	always_comb begin
		eng_next = eng_reg;
		unique case (eng_reg)
			seq_engine_pkg::ENG_LOAD: begin
				eng_next = seq_engine_pkg::ENG_RUN;
			end
			seq_engine_pkg::ENG_RUN: begin
				if (take) begin
					eng_next = seq_engine_pkg::ENG_LOAD;
				end
			end
			default: begin
				eng_next = seq_engine_pkg::ENG_LOAD;
			end
		endcase
	end

	// Reset starts with the first state.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			eng_reg <= seq_engine_pkg::ENG_LOAD;
			cur_reg <= `FIRST_STATE;
			def_reg <= '0;
		end else begin
			eng_reg <= eng_next;
			cur_reg <= cur_next;
			if (eng_reg == seq_engine_pkg::ENG_LOAD) begin
				def_reg <= store_def;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			jump_reg <= 1'b0;
		end else begin
			jump_reg <= jump_wr || (jump_reg && !take);
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seq_pre_reg <= '0;
			seq_cnt_reg <= '0;
		end else if (!run || !seq_hit) begin
			seq_pre_reg <= '0;
			seq_cnt_reg <= '0;
		end else if (seq_pre_reg == TICK_LAST) begin
			seq_pre_reg <= '0;
			seq_cnt_reg <= bump(seq_cnt_reg);
		end else begin
			seq_pre_reg <= seq_pre_reg + 12'h001;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			to_pre_reg <= '0;
			to_cnt_reg <= '0;
		end else if (!run) begin
			to_pre_reg <= '0;
			to_cnt_reg <= '0;
		end else if (to_pre_reg == TICK_LAST) begin
			to_pre_reg <= '0;
			to_cnt_reg <= bump(to_cnt_reg);
		end else begin
			to_pre_reg <= to_pre_reg + 12'h001;
		end
	end

	// ****************************************************************
	// Fault latch and interrupts.
	// ****************************************************************
	logic [INPUTS-1:0] fault_reg;
	logic [3:0]        irq_stat_reg;
	logic [3:0]        irq_mask_reg;
	logic              warn_d_reg;
	wire  [INPUTS-1:0] fault_clr;
	wire  [INPUTS-1:0] fault_set;
	wire  [3:0]        irq_clr;
	wire  [3:0]        irq_ev;

	assign fault_clr = {(wr_i && addr_i == `REG_FAULT_HIGH) ? wdata_i[4:0] : 5'h00,
	                    (wr_i && addr_i == `REG_FAULT_LOW) ? wdata_i[4:0] : 5'h00};
	assign fault_set = d_latch ? (uv_s | ov_s) : '0;
	assign irq_clr   = (wr_i && addr_i == `REG_IRQ_STAT) ? wdata_i[3:0] : 4'h0;
	assign irq_ev    = {warn && !warn_d_reg, to_exit && !mon_exit, mon_exit, take};
	assign irq_o     = |(irq_stat_reg & irq_mask_reg);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= (fault_reg & ~fault_clr) | fault_set;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat_reg <= '0;
			warn_d_reg   <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
			warn_d_reg   <= warn;
		end
	end

	// ****************************************************************
	// Host control registers.
	// ****************************************************************
	logic [2*INPUTS-1:0] src_reg;
	logic [INPUTS-1:0]   host_out_reg;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			src_reg      <= '0;
			host_out_reg <= '0;
			irq_mask_reg <= '0;
			prog_idx_reg <= '0;
		end else if (wr_i) begin
			if (addr_i == `REG_SRC) src_reg <= wdata_i[2*INPUTS-1:0];
			if (addr_i == `REG_HOST_OUT) host_out_reg <= wdata_i[INPUTS-1:0];
			if (addr_i == `REG_IRQ_MASK) irq_mask_reg <= wdata_i[3:0];
			if (addr_i == `REG_PROG_ADDR) prog_idx_reg <= wdata_i[5:0];
		end
	end

	// ****************************************************************
	// Driver outputs.
	// ****************************************************************
	logic              ref_reg;
	logic [10:0]       ref_cnt_reg;
	logic [INPUTS-1:0] drv_reg;
	wire  [INPUTS-1:0] drv_next;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ref_reg     <= 1'b0;
			ref_cnt_reg <= '0;
		end else if (ref_cnt_reg == REF_LAST) begin
			ref_cnt_reg <= '0;
			ref_reg     <= !ref_reg;
		end else begin
			ref_cnt_reg <= ref_cnt_reg + 11'h001;
		end
	end

	generate
		for (genvar i = 0; i < INPUTS; i++) begin : g_drv
			wire [1:0] s = src_reg[2*i +: 2];
			assign drv_next[i] = (s == seq_engine_pkg::SRC_HOST)   ? host_out_reg[i] :
			                     (s == seq_engine_pkg::SRC_REFCLK) ? ref_reg : d_out[i];
		end
	endgenerate

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drv_reg <= '0;
		end else begin
			drv_reg <= drv_next;
		end
	end

	assign driver_output_o = drv_reg;

	// ****************************************************************
	// Read data.
	// ****************************************************************
	logic [31:0] rdata_reg;
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr_i)
			`REG_CTRL:       rd_mux = {31'h0, jump_reg};
			`REG_STATE:      rd_mux = {25'h0, run, cur_reg};
			`REG_FAULT_LOW:  rd_mux = {27'h0, fault_reg[4:0]};
			`REG_FAULT_HIGH: rd_mux = {27'h0, fault_reg[9:5]};
			`REG_LIVE_UV:    rd_mux = 32'(uv_s);
			`REG_LIVE_OV:    rd_mux = 32'(ov_s);
			`REG_LIVE_MISC:  rd_mux = 32'({warn, sec_s, lim_s});
			`REG_SRC:        rd_mux = 32'(src_reg);
			`REG_HOST_OUT:   rd_mux = 32'(host_out_reg);
			`REG_IRQ_STAT:   rd_mux = {28'h0, irq_stat_reg};
			`REG_IRQ_MASK:   rd_mux = {28'h0, irq_mask_reg};
			`REG_PROG_ADDR:  rd_mux = {26'h0, prog_idx_reg};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rd_i ? rd_mux : 32'h0000_0000;
		end
	end

	assign rdata_o = rdata_reg;

endmodule

`default_nettype wire

// File: sequencing_engine_chk.sv
`timescale 1ns/1ns
`include "seq_engine_consts.svh"
`default_nettype none

module sequencing_engine_chk #(
	parameter int INPUTS  = 10,
	parameter int SECONDS = 5
) (
	// Clock and reset.
	input wire logic               clock_i,
	input wire logic               rstn_i,
	// Register port.
	input wire logic [7:0]         addr_i,
	input wire logic [31:0]        wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire logic [31:0]        rdata_o,
	// Inputs.
	input wire logic [INPUTS-1:0]  supply_ok_i,
	input wire logic [INPUTS-1:0]  uv_i,
	input wire logic [INPUTS-1:0]  ov_i,
	input wire logic               limit_fault_i,
	input wire logic [SECONDS-1:0] secondary_warn_i,
	// Outputs.
	input wire logic [INPUTS-1:0]  driver_output_o,
	input wire logic               irq_o
);
	// ****************************************************************
	// Helper counters and shadow mask.
	// ****************************************************************
	logic [2:0] uv_cnt;
	logic [2:0] ov_cnt;
	logic [2:0] rst_cnt;
	logic [3:0] mask_sh;
	wire        quiet = uv_cnt > 3'h5 && ov_cnt > 3'h5 && uv_i == '0 && ov_i == '0;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			uv_cnt  <= 3'h0;
			ov_cnt  <= 3'h0;
			rst_cnt <= 3'h0;
			mask_sh <= 4'h0;
		end else begin
			uv_cnt  <= $changed(uv_i) ? 3'h0 : (uv_cnt == 3'h7 ? uv_cnt : uv_cnt + 3'h1);
			ov_cnt  <= $changed(ov_i) ? 3'h0 : (ov_cnt == 3'h7 ? ov_cnt : ov_cnt + 3'h1);
			rst_cnt <= (rst_cnt == 3'h7) ? rst_cnt : rst_cnt + 3'h1;
			if (wr_i && addr_i == `REG_IRQ_MASK) begin
				mask_sh <= wdata_i[3:0];
			end
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (rd_i && addr_i == 8'h3c |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_prog_words: assert property (rd_i && addr_i inside {`REG_PROG_W0, `REG_PROG_W1,
		`REG_PROG_W2} |=> rdata_o == 32'h0)
		else $error("definition word readable");
	a_state_range: assert property (rd_i && addr_i == `REG_STATE |=>
		rdata_o[31:7] == 25'h0 && rdata_o[5:0] != 6'h3f)
		else $error("current state out of range");
	a_live_uv: assert property (rd_i && addr_i == `REG_LIVE_UV && uv_cnt > 3'h5 |=>
		rdata_o[INPUTS-1:0] == $past(uv_i) && rdata_o[31:INPUTS] == '0)
		else $error("undervoltage status not live");
	a_live_ov: assert property (rd_i && addr_i == `REG_LIVE_OV && ov_cnt > 3'h5 |=>
		rdata_o[INPUTS-1:0] == $past(ov_i) && rdata_o[31:INPUTS] == '0)
		else $error("overvoltage status not live");
	a_fault_clear: assert property (wr_i && addr_i == `REG_FAULT_LOW && wdata_i == 32'hffffffff
		&& quiet ##2 rd_i && addr_i == `REG_FAULT_LOW |=> rdata_o == 32'h0)
		else $error("fault latch not cleared");
	a_irq_masked: assert property (mask_sh == 4'h0 |-> !irq_o)
		else $error("interrupt while all masked");
	a_out_reset: assert property (rst_cnt < 3'h3 |-> driver_output_o == '0)
		else $error("outputs early after reset");
	a_out_hold: assert property ($changed(driver_output_o) && !$past(wr_i) |=>
		$stable(driver_output_o))
		else $error("outputs changed within a state");

	c_state_read: cover property (rd_i && addr_i == `REG_STATE);
	c_irq_high: cover property (irq_o);
	c_out_move: cover property ($changed(driver_output_o));
endmodule

`default_nettype wire

// File: supply_model.sv
`timescale 1ns/1ns
`default_nettype none

module supply_model #(
	parameter int RAMP = 20
) (
	// Clock.
	input  wire logic       clock_i,
	// Enables and forced faults.
	input  wire logic [9:0] drive_i,
	input  wire logic [9:0] kill_i,
	// Detector levels.
	output logic      [9:0] ok_o,
	output logic      [9:0] uv_o
);
	// ****************************************************************
	// A supply comes up RAMP cycles after its enable.
	// ****************************************************************
	logic [7:0] up_cnt [10] = '{default: 8'h0};
	logic [9:0] ramped;

	always_ff @(posedge clock_i) begin
		for (int i = 0; i < 10; i++) begin
			up_cnt[i] <= !drive_i[i] ? 8'h0 : (up_cnt[i] == 8'(RAMP) ? up_cnt[i] : up_cnt[i] + 8'h1);
		end
	end

	always_comb begin
		for (int i = 0; i < 10; i++) begin
			ramped[i] = up_cnt[i] == 8'(RAMP);
		end
	end

	assign ok_o = ramped & ~kill_i;
	assign uv_o = kill_i | (drive_i & ~ramped);
endmodule

`default_nettype wire

// File: sequencing_engine_test.sv
`timescale 1ns/1ns
`include "seq_engine_consts.svh"
`default_nettype none

module sequencing_engine_test;
	logic        clock_i;
	logic        rstn_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [9:0]  kill;
	logic [9:0]  ov_i;
	logic        limit_fault_i;
	logic [4:0]  secondary_warn_i;
	logic        lvl;
	wire  [31:0] rdata_o;
	wire  [9:0]  supply_ok_i;
	wire  [9:0]  uv_i;
	wire  [9:0]  driver_output_o;
	wire         irq_o;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          cyc;

	sequencing_engine sequencing_engine_i (.clock_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .supply_ok_i, .uv_i, .ov_i, .limit_fault_i, .secondary_warn_i,
		.driver_output_o, .irq_o);
	supply_model supply_model_i (.clock_i, .drive_i(driver_output_o), .kill_i(kill),
		.ok_o(supply_ok_i), .uv_o(uv_i));

	// ****************************************************************
	// Bus tasks and checks.
	// ****************************************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i   <= 1'b0;
		@(posedge clock_i);
		chk(n, e, rdata_o);
	endtask

	task automatic prog(input logic [5:0] i, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] c);
		wr(`REG_PROG_ADDR, {26'h0, i});
		wr(`REG_PROG_W1, b);
		wr(`REG_PROG_W2, c);
		wr(`REG_PROG_W0, a);
	endtask

	task automatic wait_out(input logic [9:0] v, input int lim, output int c);
		c = 0;
		while (driver_output_o !== v && c < lim) begin
			@(posedge clock_i);
			c++;
		end
		chk("driver_output", {22'h0, v}, {22'h0, driver_output_o});
	endtask

	function automatic logic [31:0] w0f(input logic [9:0] o, input logic l,
		input logic [3:0] s, input logic [5:0] n, input logic [5:0] m);
		return {4'h0, m, n, 1'b1, s, l, o};
	endfunction

	task automatic complete_run();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****************************************************************
	// Clock, watchdog and tests.
	// ****************************************************************
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	initial begin
		repeat (40000) @(posedge clock_i);
		$display("[FAIL] watchdog expected 0 seen 1");
		error_cnt++;
		complete_run();
	end

	initial begin
		rstn_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		kill = 10'h000;
		ov_i = 10'h000;
		limit_fault_i = 1'b0;
		secondary_warn_i = 5'h00;
		repeat (10) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(`REG_FAULT_LOW, 32'h0, "fault_low");
		rd(`REG_IRQ_MASK, 32'h0, "irq_mask");
		prog(6'h01, w0f(10'h003, 1'b1, 4'h1, 6'h02, 6'h04), 32'h00040002, 32'h00300401);
		prog(6'h02, w0f(10'h007, 1'b0, 4'ha, 6'h00, 6'h00), 32'h0, 32'h0);
		prog(6'h03, w0f(10'h009, 1'b0, 4'hf, 6'h3e, 6'h00), 32'h0, 32'h0);
		prog(6'h04, w0f(10'h011, 1'b0, 4'hf, 6'h00, 6'h00), 32'h0, 32'h0);
		prog(6'h3e, w0f(10'h3ff, 1'b0, 4'hf, 6'h00, 6'h00), 32'h0, 32'h0);
		prog(6'h00, w0f(10'h001, 1'b0, 4'h0, 6'h01, 6'h00), 32'h0, 32'h0);
		wait_out(10'h003, 300, cyc);
		repeat (1200) @(posedge clock_i);
		kill <= 10'h002;
		repeat (20) @(posedge clock_i);
		rd(`REG_LIVE_UV, 32'h002, "live_uv");
		repeat (80) @(posedge clock_i);
		kill <= 10'h000;
		wait_out(10'h007, 5100, cyc);
		chk("seq_hold", 32'h1, 32'(cyc >= 4990 && cyc <= 5030));
		rd(`REG_FAULT_LOW, 32'h002, "fault_low");
		kill <= 10'h020;
		repeat (20) @(posedge clock_i);
		kill <= 10'h000;
		repeat (10) @(posedge clock_i);
		rd(`REG_FAULT_HIGH, 32'h0, "fault_high");
		wr(`REG_FAULT_LOW, 32'hffffffff);
		rd(`REG_FAULT_LOW, 32'h0, "fault_low");
		ov_i <= 10'h155;
		repeat (10) @(posedge clock_i);
		rd(`REG_LIVE_OV, 32'h155, "live_ov");
		ov_i <= 10'h000;
		wr(`REG_IRQ_MASK, 32'h2);
		limit_fault_i <= 1'b1;
		secondary_warn_i <= 5'h04;
		repeat (8) @(posedge clock_i);
		rd(`REG_LIVE_MISC, 32'h49, "live_misc");
		limit_fault_i <= 1'b0;
		secondary_warn_i <= 5'h00;
		wait_out(10'h003, 100, cyc);
		kill <= 10'h001;
		wait_out(10'h011, 20, cyc);
		chk("monitor_delay", 32'h1, 32'(cyc <= 10));
		chk("irq", 32'h1, {31'h0, irq_o});
		kill <= 10'h000;
		wr(`REG_IRQ_STAT, 32'h2);
		@(posedge clock_i);
		chk("irq", 32'h0, {31'h0, irq_o});
		kill <= 10'h002;
		wr(`REG_CTRL, 32'h1);
		wait_out(10'h003, 100, cyc);
		wait_out(10'h009, 10100, cyc);
		chk("timeout", 32'h1, 32'(cyc >= 9990 && cyc <= 10030));
		rd(`REG_IRQ_STAT, 32'hd, "irq_stat");
		kill <= 10'h000;
		wr(`REG_CTRL, 32'h1);
		wait_out(10'h3ff, 100, cyc);
		rd(`REG_STATE, 32'h7e, "state");
		rd(`REG_CTRL, 32'h0, "jump_pending");
		rd(8'h3c, 32'h0, "unmapped");
		wr(`REG_SRC, 32'h00060000);
		wr(`REG_HOST_OUT, 32'h0);
		repeat (3) @(posedge clock_i);
		#1;
		chk("host_bit", 32'h0, {31'h0, driver_output_o[9]});
		for (int k = 0; k < 2; k++) begin
			lvl = driver_output_o[8];
			cyc = 0;
			while (driver_output_o[8] === lvl && cyc < 1300) begin
				@(posedge clock_i);
				#1;
				cyc++;
			end
		end
		chk("refclk_half", 32'd1250, 32'(cyc));
		complete_run();
	end
endmodule

bind sequencing_engine sequencing_engine_chk #(.INPUTS(INPUTS), .SECONDS(SECONDS))
	sequencing_engine_chk_i (.clock_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.supply_ok_i, .uv_i, .ov_i, .limit_fault_i, .secondary_warn_i, .driver_output_o, .irq_o);

`default_nettype wire
